// ---- pkg/sfl_pkg.sv ----
// package: register map, field layout and timing of the serial frame loop control block
`default_nettype none
package sfl_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_FRAME_CONTROL = 6'h02;
  localparam logic [5:0] IDX_CONTROL       = 6'h03;
  localparam logic [5:0] IDX_STATUS        = 6'h04;
  localparam logic [5:0] IDX_STATUS_TWO    = 6'h05;
  localparam logic [5:0] IDX_DATA          = 6'h07;
  // ---------------------------------------------------------------
  // frame_control fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_LOOP_SELECT     = 7;
  localparam int unsigned BIT_WAIT_STOP       = 6;
  localparam int unsigned BIT_RECEIVER_SOURCE = 5;
  localparam int unsigned BIT_NINE_BIT_FORMAT = 4;
  localparam int unsigned BIT_WAKE_ADDRESS    = 3;
  localparam int unsigned BIT_IDLE_COUNT_STOP = 2;
  localparam int unsigned BIT_PARITY_ON       = 1;
  localparam int unsigned BIT_ODD_PARITY      = 0;
  localparam logic [7:0]  FRAME_CONTROL_RESET = 8'h00;
  // ---------------------------------------------------------------
  // control, status and status_register_two fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_TX_ENABLE       = 3;
  localparam int unsigned BIT_RX_ENABLE       = 2;
  localparam int unsigned BIT_SLEEP           = 1;
  localparam int unsigned BIT_STAT_IDLE       = 4;
  localparam int unsigned BIT_STAT_FRAME_ERR  = 1;
  localparam int unsigned BIT_STAT_PARITY_ERR = 0;
  localparam int unsigned BIT_ALTERNATE_MAP   = 7;
  // ---------------------------------------------------------------
  // timing and buffering
  // ---------------------------------------------------------------
  localparam logic [4:0] BIT_CYCLES     = 5'h10;
  localparam logic [4:0] HALF_BIT       = 5'h08;
  localparam logic [7:0] IDLE_CYCLES_8  = 8'(10 * 16);
  localparam logic [7:0] IDLE_CYCLES_9  = 8'(11 * 16);
  localparam int unsigned FIFO_WIDTH    = 9;
  localparam int unsigned FIFO_DEPTH    = 4;
  typedef enum logic [1:0] {
    SFL_RX_IDLE  = 2'b00,
    SFL_RX_START = 2'b01,
    SFL_RX_DATA  = 2'b11,
    SFL_RX_STOP  = 2'b10
  } sfl_rx_state_e;
endpackage
`default_nettype wire

// ---- rtl/sfl_serial_frame_loop_control.sv ----
// serial frame loop control: ahb-lite registers, transmit fifo, transmitter and receiver
//
// Contract
// - loop select cuts the receive pin off and feeds the receiver from the transmit line.
// - loop clear normal; loop with source 0 internal; source 1 single-wire pin.
// - wait-stop select halts the whole interface while wait mode is active.
// - format bit picks eight or nine data bits between start and stop.
// - wake bit picks idle line or address mark to end receiver sleep.
// - idle count starts after start bit, or only after stop bit.
// - parity on generates and checks parity in the character's top bit.
// - parity type picks even or odd sense of the parity bit.
// - frame control is read and written anytime while alternate map is clear.
// - alternate map bit in status register two hides the frame control register.
//
// Register access over AHB-Lite was chosen for this implementation.
`default_nettype none

module sfl_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // pointers wrap naturally, so depth must be a power of two
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire logic        push;
  wire logic        pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sfl_serial_frame_loop_control (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        wait_mode,
  input  wire logic        rxd,
  input  wire logic        txd_in,
  output logic             txd_out,
  output logic             txd_oe
);
  import sfl_pkg::*;

  // ---------------------------------------------------------------
  // decode helper
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [5:0] idx, input logic [5:0] which, input logic mapped);
    reg_hit = mapped && (idx == which);
  endfunction

  // inserts parity into the top bit when enabled
  function automatic logic [8:0] frame_char(input logic [8:0] d, input logic nine, input logic par_on,
                                            input logic odd);
    logic par;
    par = (nine ? (^d[7:0]) : (^d[6:0])) ^ odd;
    if (nine) begin
      frame_char = {par_on ? par : d[8], d[7:0]};
    end else begin
      frame_char = {1'b0, par_on ? par : d[7], d[6:0]};
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]     frame_control;
  logic           alt_map;
  logic           tx_en;
  logic           rx_en;
  logic           sleep;
  logic           wr_pend;
  logic [5:0]     wr_idx;
  logic           push_pend;
  logic           tx_busy;
  logic [10:0]    tx_shift;
  logic [3:0]     tx_bits;
  logic [4:0]     tx_timer;
  logic           rxd_s1;
  logic           rxd_s2;
  logic           txd_s1;
  logic           txd_s2;
  sfl_rx_state_e  rx_state;
  logic [4:0]     rx_timer;
  logic [3:0]     rx_cnt;
  logic [8:0]     rx_shift;
  logic [8:0]     rx_data;
  logic           rx_full;
  logic           frame_err;
  logic           parity_err;
  logic           idle_flag;
  logic [7:0]     ones_cnt;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic       loop_sel;
  wire logic       wait_stop;
  wire logic       rx_source;
  wire logic       nine;
  wire logic       wake_addr;
  wire logic       idle_after_stop;
  wire logic       par_on;
  wire logic       odd_par;
  wire logic       addr_take;
  wire logic       addr_mapped;
  wire logic [5:0] addr_idx;
  wire logic       rd_fc;
  wire logic       rd_ctrl;
  wire logic       rd_stat;
  wire logic       rd_st2;
  wire logic       rd_data;
  wire logic [8:0] rd_mux;
  wire logic       wr_fc;
  wire logic       wr_ctrl;
  wire logic       wr_stat;
  wire logic       wr_st2;
  wire logic       rx_pop;

  assign loop_sel        = frame_control[BIT_LOOP_SELECT];
  assign wait_stop       = frame_control[BIT_WAIT_STOP];
  assign rx_source       = frame_control[BIT_RECEIVER_SOURCE];
  assign nine            = frame_control[BIT_NINE_BIT_FORMAT];
  assign wake_addr       = frame_control[BIT_WAKE_ADDRESS];
  assign idle_after_stop = frame_control[BIT_IDLE_COUNT_STOP];
  assign par_on          = frame_control[BIT_PARITY_ON];
  assign odd_par         = frame_control[BIT_ODD_PARITY];

  assign addr_take   = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign addr_mapped = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
  assign addr_idx    = haddr[7:2];
  assign rd_fc       = reg_hit(addr_idx, IDX_FRAME_CONTROL, addr_mapped) && !alt_map;
  assign rd_ctrl     = reg_hit(addr_idx, IDX_CONTROL, addr_mapped);
  assign rd_stat     = reg_hit(addr_idx, IDX_STATUS, addr_mapped);
  assign rd_st2      = reg_hit(addr_idx, IDX_STATUS_TWO, addr_mapped);
  assign rd_data     = reg_hit(addr_idx, IDX_DATA, addr_mapped);
  assign wr_fc       = wr_pend && (wr_idx == IDX_FRAME_CONTROL) && !alt_map;
  assign wr_ctrl     = wr_pend && (wr_idx == IDX_CONTROL);
  assign wr_stat     = wr_pend && (wr_idx == IDX_STATUS);
  assign wr_st2      = wr_pend && (wr_idx == IDX_STATUS_TWO);
  assign rx_pop      = addr_take && !hwrite && rd_data;

  // ---------------------------------------------------------------
  // fifo, activity and routing
  // ---------------------------------------------------------------
  wire logic       fifo_ready;
  wire logic       fifo_valid;
  wire logic [8:0] fifo_data;
  wire logic       active;
  wire logic       tx_run;
  wire logic       rx_run;
  wire logic       tx_load;
  wire logic [8:0] tx_char;
  wire logic       rx_in;

  assign active  = !(wait_mode && wait_stop);
  assign tx_run  = tx_en && active;
  assign rx_run  = rx_en && active;
  assign tx_load = fifo_valid && !tx_busy && tx_run;
  assign tx_char = frame_char(fifo_data, nine, par_on, odd_par);
  // internal loop taps the transmitter flop; single-wire takes the pin
  assign rx_in   = !loop_sel ? rxd_s2 : (rx_source ? txd_s2 : txd_out);

  sfl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (push_pend),
    .in_ready  (fifo_ready),
    .in_data   (hwdata[8:0]),
    .out_valid (fifo_valid),
    .out_ready (!tx_busy && tx_run),
    .out_data  (fifo_data)
  );

  // ---------------------------------------------------------------
  // receive decode
  // ---------------------------------------------------------------
  wire logic       rx_done;
  wire logic [8:0] rx_char;
  wire logic       rx_msb;
  wire logic       rx_par_bad;
  wire logic       rx_accept;
  wire logic       count_en;
  wire logic [7:0] idle_target;
  wire logic       idle_hit;
  wire logic       wake_now;

  assign rx_done     = (rx_state == SFL_RX_STOP) && (rx_timer == BIT_CYCLES - 5'h1);
  assign rx_char     = nine ? rx_shift : {1'b0, rx_shift[8:1]};
  assign rx_msb      = nine ? rx_char[8] : rx_char[7];
  assign rx_par_bad  = par_on && (frame_char(rx_char, nine, par_on, odd_par) != rx_char);
  assign rx_accept   = rx_done && (!sleep || (wake_addr && rx_msb));
  assign count_en    = rx_run && rx_in && (!idle_after_stop || (rx_state == SFL_RX_IDLE));
  assign idle_target = nine ? IDLE_CYCLES_9 : IDLE_CYCLES_8;
  assign idle_hit    = count_en && (ones_cnt == idle_target - 8'h1);
  assign wake_now    = sleep && ((!wake_addr && idle_hit) || (wake_addr && rx_done && rx_msb));

  assign rd_mux = rd_fc   ? {1'b0, frame_control} :
                  rd_ctrl ? {5'h00, tx_en, rx_en, sleep, 1'b0} :
                  rd_stat ? {1'b0, !fifo_ready, tx_busy, rx_full, idle_flag, sleep, 1'b0, frame_err, parity_err} :
                  rd_st2  ? {1'b0, alt_map, 7'h00} :
                  rd_data ? rx_data : 9'h000;

  // ---------------------------------------------------------------
  // bus slave and registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      hrdata        <= 32'h0000_0000;
      wr_pend       <= 1'b0;
      wr_idx        <= 6'h00;
      push_pend     <= 1'b0;
      frame_control <= FRAME_CONTROL_RESET;
      alt_map       <= 1'b0;
      tx_en         <= 1'b0;
      rx_en         <= 1'b0;
      sleep         <= 1'b0;
    end else begin
      wr_pend <= addr_take && hwrite && !reg_hit(addr_idx, IDX_DATA, addr_mapped);
      wr_idx  <= addr_mapped ? addr_idx : 6'h3f;
      // data writes wait until the fifo has room
      if (addr_take && hwrite && reg_hit(addr_idx, IDX_DATA, addr_mapped)) begin
        push_pend <= 1'b1;
        hreadyout <= 1'b0;
      end else if (push_pend && fifo_ready) begin
        push_pend <= 1'b0;
        hreadyout <= 1'b1;
      end
      if (addr_take && !hwrite) begin
        hrdata <= {23'h00_0000, rd_mux};
      end
      if (wr_fc) begin
        frame_control <= hwdata[7:0];
      end
      if (wr_st2) begin
        alt_map <= hwdata[BIT_ALTERNATE_MAP];
      end
      if (wr_ctrl) begin
        tx_en <= hwdata[BIT_TX_ENABLE];
        rx_en <= hwdata[BIT_RX_ENABLE];
        sleep <= hwdata[BIT_SLEEP];
      end else if (wake_now) begin
        sleep <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  // disabling mid-frame cuts the character short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_out  <= 1'b1;
      txd_oe   <= 1'b0;
      tx_busy  <= 1'b0;
      tx_shift <= 11'h7ff;
      tx_bits  <= 4'h0;
      tx_timer <= 5'h00;
    end else begin
      txd_oe <= tx_run;
      if (!tx_run) begin
        txd_out <= 1'b1;
        tx_busy <= 1'b0;
      end else if (tx_load) begin
        txd_out  <= 1'b0;
        tx_shift <= nine ? {2'b11, tx_char} : {3'b111, tx_char[7:0]};
        tx_bits  <= nine ? 4'ha : 4'h9;
        tx_timer <= 5'h00;
        tx_busy  <= 1'b1;
      end else if (tx_busy && (tx_timer == BIT_CYCLES - 5'h1)) begin
        tx_timer <= 5'h00;
        if (tx_bits == 4'h0) begin
          tx_busy <= 1'b0;
        end else begin
          txd_out  <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bits  <= tx_bits - 4'h1;
        end
      end else if (tx_busy) begin
        tx_timer <= tx_timer + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_s1   <= 1'b1;
      rxd_s2   <= 1'b1;
      txd_s1   <= 1'b1;
      txd_s2   <= 1'b1;
      rx_state <= SFL_RX_IDLE;
      rx_timer <= 5'h00;
      rx_cnt   <= 4'h0;
      rx_shift <= 9'h000;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      txd_s1 <= txd_in;
      txd_s2 <= txd_s1;
      rx_timer <= rx_timer + 5'h01;
      if (!rx_run) begin
        rx_state <= SFL_RX_IDLE;
      end else begin
        unique case (rx_state)
          SFL_RX_IDLE: begin
            rx_timer <= 5'h00;
            if (!rx_in) begin
              rx_state <= SFL_RX_START;
            end
          end
          SFL_RX_START: begin
            // a start bit gone high by mid-bit is a glitch
            if (rx_timer == HALF_BIT - 5'h1) begin
              rx_timer <= 5'h00;
              rx_cnt   <= 4'h0;
              rx_state <= rx_in ? SFL_RX_IDLE : SFL_RX_DATA;
            end
          end
          SFL_RX_DATA: begin
            if (rx_timer == BIT_CYCLES - 5'h1) begin
              rx_timer <= 5'h00;
              rx_shift <= {rx_in, rx_shift[8:1]};
              rx_cnt   <= rx_cnt + 4'h1;
              if (rx_cnt == (nine ? 4'h8 : 4'h7)) begin
                rx_state <= SFL_RX_STOP;
              end
            end
          end
          SFL_RX_STOP: begin
            if (rx_done) begin
              rx_state <= SFL_RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data    <= 9'h000;
      rx_full    <= 1'b0;
      frame_err  <= 1'b0;
      parity_err <= 1'b0;
      idle_flag  <= 1'b0;
      ones_cnt   <= 8'h00;
    end else begin
      if (rx_accept) begin
        rx_data <= rx_char;
      end
      rx_full    <= rx_accept || (rx_full && !rx_pop);
      frame_err  <= (rx_accept && !rx_in) || (frame_err && !(wr_stat && hwdata[BIT_STAT_FRAME_ERR]));
      parity_err <= (rx_accept && rx_par_bad) || (parity_err && !(wr_stat && hwdata[BIT_STAT_PARITY_ERR]));
      idle_flag  <= (idle_hit && !sleep) || (idle_flag && !(wr_stat && hwdata[BIT_STAT_IDLE]));
      if (!count_en) begin
        ones_cnt <= 8'h00;
      end else if (ones_cnt < idle_target) begin
        ones_cnt <= ones_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/sfl_properties.sv ----
// checker: bus answers, map visibility and line behaviour of the frame loop control block
`default_nettype none
module sfl_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        wait_mode,
  input wire logic        rxd,
  input wire logic        txd_in,
  input wire logic        txd_out,
  input wire logic        txd_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // shadow of frame_control and the map select
  // ------------------------------------------
  logic            wr_pend, alt;
  logic [7:0]      a_q, fc;
  wire logic       taken  = hsel && hready && htrans[1] && hsize == 3'b010;
  wire logic [7:0] fc_vis = alt ? 8'h00 : fc;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_pend, alt, a_q, fc} <= '0;
    end else begin
      if (hready) wr_pend <= taken && hwrite;
      if (hready && taken) a_q <= haddr[7:0];
      if (wr_pend && hready && a_q == 8'h08 && !alt) fc <= hwdata[7:0];
      if (wr_pend && hready && a_q == 8'h14) alt <= hwdata[7];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------
  // properties
  // ------------------------------------------
  okay_resp_a: assert property (!hresp) else $error("bus answer not okay");
  upper_zero_a: assert property (hrdata[31:9] == 23'h00_0000) else $error("read data upper bits set");
  unmapped_rd_a: assert property (taken && !hwrite && haddr == 32'h0000_0040 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  read_zero_wait_a: assert property (taken && !hwrite |=> hreadyout) else $error("read took a wait state");
  fc_read_a: assert property (taken && !hwrite && haddr == 32'h0000_0008
    |=> hrdata == {24'h00_0000, $past(fc_vis)}) else $error("frame control read wrong");
  wait_stop_a: assert property (wait_mode && fc[6] ##1 wait_mode && fc[6] |-> !txd_oe && txd_out)
    else $error("interface active in wait mode");
  data_wait_a: assert property (taken && hwrite && haddr == 32'h0000_001C |=> !hreadyout)
    else $error("data write without wait state");
  reset_idle_a: assert property ($rose(hresetn) |-> hreadyout && !txd_oe && txd_out && hrdata == 32'h0000_0000)
    else $error("outputs not idle after reset");
  bit_hold_a: assert property ($fell(txd_out) && !wait_mode |-> (!txd_out) [*8])
    else $error("low bit shorter than half a bit time");
  cover property (taken && hwrite && haddr == 32'h0000_001C ##1 (!hreadyout) [*8]);
  cover property (wait_mode && fc[6] && !txd_oe);
  cover property (alt && taken && !hwrite && haddr == 32'h0000_0008);
endmodule

bind sfl_serial_frame_loop_control sfl_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .wait_mode(wait_mode), .rxd(rxd), .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe)
);
`default_nettype wire

// ---- test/sfl_remote_node.sv ----
// partner: remote serial node on the transmit and receive lines
`default_nettype none
module sfl_remote_node (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic nine,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q [$];
  logic [8:0] cap;
  logic       line = 1'b1;
  logic       jam  = 1'b0;
  // jam holds the pin low to prove the receiver is cut off from it
  assign rxd = line & ~jam;
  // ------------------------------------------
  // frame sender and mid-bit sampler
  // ------------------------------------------
  task automatic send(input logic [8:0] v);
    line <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      line <= v[i];
      repeat (16) @(posedge clk);
    end
    line <= 1'b1;
    repeat (16) @(posedge clk);
  endtask
  initial forever begin
    @(negedge txd);
    cap = '0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (16) @(posedge clk);
      cap[i] = txd;
    end
    repeat (16) @(posedge clk);
    rx_q.push_back(cap);
  end
endmodule
`default_nettype wire

// ---- test/tb_serial_frame_loop_control.sv ----
// testbench: register map, frame formats, buffering, wait stop, wakeup and loop routing
`default_nettype none
`define SFL_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_serial_frame_loop_control;
  import sfl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_FC = {IDX_FRAME_CONTROL, 2'b00};
  localparam logic [7:0] A_CT = {IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_S2 = {IDX_STATUS_TWO, 2'b00};
  localparam logic [7:0] A_DT = {IDX_DATA, 2'b00};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wait_mode = 1'b0, nine = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic        hreadyout, hresp, txd_out, txd_oe, rxd;
  logic [8:0]  d, e;
  logic [7:0]  fcv [7] = '{8'h00, 8'h20, 8'h10, 8'h02, 8'h03, 8'h12, 8'h13};
  int          n_errors = 0, num_checks = 0;
  wire logic   txd_pin = txd_oe ? txd_out : 1'b1; // pull-up while the transmitter lets go
  initial forever #20 hclk = ~hclk;
  sfl_serial_frame_loop_control dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wait_mode(wait_mode), .rxd(rxd), .txd_in(txd_pin), .txd_out(txd_out), .txd_oe(txd_oe)
  );
  sfl_remote_node u_node (.clk(hclk), .txd(txd_pin), .nine(nine), .rxd(rxd));
  function automatic logic [8:0] framed(input logic [7:0] fc, input logic [8:0] v);
    logic [8:0] r;
    r = fc[4] ? v : {1'b0, v[7:0]};
    if (fc[1] && fc[4]) r[8] = ^r[7:0] ^ fc[0];
    if (fc[1] && !fc[4]) r[7] = ^r[6:0] ^ fc[0];
    return r;
  endfunction
  task automatic tally_and_finish;
    $display("TB counts: checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 9999) begin
      n_errors++;
      $display("MISMATCH t=%0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // data writes may stall for a whole frame, so every wait is a counted loop
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 9999);
    {hsel, htrans} <= 3'b000;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 9999);
    rd = hrdata;
    hang(n);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, '0);
    `SFL_CHK(rd, x)
  endtask
  task automatic wait_rx;
    int k;
    k = 0;
    do bus(1'b0, A_ST, '0); while (rd[5] !== 1'b1 && ++k < 9999);
    hang(k);
  endtask
  task automatic get_tx(input logic [8:0] x);
    int k;
    k = 0;
    while (u_node.rx_q.size() == 0 && ++k < 9999) @(posedge hclk);
    hang(k);
    d = u_node.rx_q.pop_front();
    `SFL_CHK(d, x)
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(A_FC, 32'h0000_0000);
    rchk(A_S2, 32'h0000_0000);
    bus(1'b1, 8'h40, 32'h0000_00FF);
    rchk(8'h40, 32'h0000_0000);
    bus(1'b1, A_FC, 32'h0000_00A5);
    rchk(A_FC, 32'h0000_00A5);
    bus(1'b1, A_S2, 32'h0000_0080);
    rchk(A_FC, 32'h0000_0000);
    bus(1'b1, A_FC, 32'h0000_0000);
    bus(1'b1, A_S2, 32'h0000_0000);
    rchk(A_FC, 32'h0000_00A5);
    $display("test register map done");
    bus(1'b1, A_CT, 32'h0000_000C);
    foreach (fcv[i]) begin
      bus(1'b1, A_FC, {24'h00_0000, fcv[i]});
      nine = fcv[i][4];
      e = framed(fcv[i], 9'h1A5);
      bus(1'b1, A_DT, 32'h0000_01A5);
      get_tx(e);
      u_node.send(e);
      wait_rx;
      `SFL_CHK(rd[1:0], 2'b00)
      rchk(A_DT, {23'h00_0000, e});
    end
    bus(1'b1, A_FC, 32'h0000_0002);
    nine = 1'b0;
    u_node.send(9'h001);
    wait_rx;
    `SFL_CHK(rd[1:0], 2'b01)
    bus(1'b1, A_ST, 32'h0000_0001);
    rchk(A_DT, 32'h0000_0001);
    $display("test frame formats done");
    for (int k = 0; k < 6; k++) bus(1'b1, A_DT, 32'h0000_0010 + k);
    bus(1'b0, A_ST, '0);
    `SFL_CHK(rd[7], 1'b1)
    for (int k = 0; k < 6; k++) get_tx(framed(8'h02, 9'h010 + 9'(k)));
    bus(1'b0, A_ST, '0);
    `SFL_CHK(rd[7], 1'b0)
    $display("test buffering done");
    bus(1'b1, A_FC, 32'h0000_0040);
    wait_mode <= 1'b1;
    bus(1'b1, A_DT, 32'h0000_005A);
    repeat (400) @(posedge hclk);
    `SFL_CHK(u_node.rx_q.size(), 0)
    wait_mode <= 1'b0;
    get_tx(9'h05A);
    bus(1'b1, A_FC, 32'h0000_0000);
    wait_mode <= 1'b1;
    bus(1'b1, A_DT, 32'h0000_003C);
    get_tx(9'h03C);
    wait_mode <= 1'b0;
    $display("test wait mode done");
    bus(1'b1, A_FC, 32'h0000_0008);
    bus(1'b1, A_CT, 32'h0000_000E);
    u_node.send(9'h005);
    bus(1'b0, A_ST, '0);
    `SFL_CHK(rd[5], 1'b0)
    u_node.send(9'h085);
    wait_rx;
    rchk(A_DT, 32'h0000_0085);
    rchk(A_CT, 32'h0000_000C);
    $display("test wakeup done");
    // an all-ones character shows where idle counting starts
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, A_FC, m ? 32'h0000_0004 : 32'h0000_0000);
      bus(1'b1, A_ST, 32'h0000_0010);
      u_node.send(9'h0FF);
      repeat (40) @(posedge hclk);
      bus(1'b0, A_ST, '0);
      `SFL_CHK(rd[4], m == 0)
      repeat (200) @(posedge hclk);
      bus(1'b0, A_ST, '0);
      `SFL_CHK(rd[4], 1'b1)
      bus(1'b0, A_DT, '0);
    end
    bus(1'b1, A_FC, 32'h0000_0000);
    bus(1'b1, A_CT, 32'h0000_000E);
    u_node.send(9'h0FF);
    repeat (40) @(posedge hclk);
    rchk(A_CT, 32'h0000_000C);
    bus(1'b0, A_ST, '0);
    `SFL_CHK(rd[5], 1'b0)
    $display("test idle done");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, A_FC, i ? 32'h0000_00A0 : 32'h0000_0080);
      u_node.jam <= 1'b1;
      bus(1'b1, A_DT, 32'h0000_0036);
      wait_rx;
      rchk(A_DT, 32'h0000_0036);
      u_node.jam <= 1'b0;
      get_tx(9'h036);
    end
    $display("test loop routing done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
